// ==== hdl/scs_clock_switch.sv ====
// Purpose: System clock source selection with external clock backup
// Assumes: One 100 MHz clock; plain register port with read data one cycle later
// Notes:   Clock gates are break-before-make enables for the clock tree mux
//
// The placing of the registers and strobed register access were decided locally.
module scs_clock_switch
    import scs_pkg::*;
#(
    parameter int HALT_TIMEOUT = HALT_CYCLES,
    parameter int REF_W        = 16
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrEn,
    input  wire logic       rdEn,
    output logic      [7:0] rdData,
    // External pins
    input  wire logic       extOsc,
    input  wire logic       refIn,
    // Oscillator trim
    input  wire logic [7:0] trimDefault,
    output logic      [7:0] trimValue,
    // Clock tree control
    output logic            rcClkGate,
    output logic            extClkGate,
    output logic            clkIsExt,
    // Interrupt
    output logic            irq
);

    logic             bake;
    logic             sel;
    logic             ie;
    logic             flag;
    logic             armed;
    logic             halted;
    logic             prevHalted;
    logic             haltRise;
    logic             haltSeen;
    logic             target;
    logic             setFlag;
    logic             toExtDone;
    logic             trimLoaded;
    logic             wrCk;
    logic             rdCk;
    logic             rdEvt;
    logic [7:0]       ctrlView;
    logic [EVT_W-1:0] evtSet;
    logic [EVT_W-1:0] evtStatus;
    logic [EVT_W-1:0] evtMask;
    logic [GAP_W-1:0] gapCnt;
    scs_state_t       state;
    logic             refS1;
    logic             refS2;
    logic             refS3;
    logic             refLevel;
    logic             refRise;
    logic [REF_W-1:0] refCnt;
    logic [REF_W-1:0] refPeriod;
    logic [15:0]      refView;

    assign wrCk  = wrEn && (addr == ADDR_CTRL);
    assign rdCk  = rdEn && (addr == ADDR_CTRL);
    assign rdEvt = rdEn && (addr == ADDR_EVT_STATUS);

    // Halt detector
    scs_halt_detect #(
        .TIMEOUT (HALT_TIMEOUT),
        .CW      (16)
    ) u_halt (
        .clk     (clk),
        .rst     (rst),
        .enable  (bake),
        .extOsc  (extOsc),
        .halted  (halted)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prevHalted <= RST_HALT;
        end else begin
            prevHalted <= halted;
        end
    end

    assign haltSeen = bake && halted;
    assign haltRise = bake && halted && !prevHalted;

    // Backup enable and interrupt enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bake <= RST_BAKE;
            ie   <= RST_IE;
        end else if (wrCk) begin
            bake <= wrData[BIT_BAKE];
            ie   <= wrData[BIT_IE];
        end
    end

    // Source select bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sel <= RST_SEL;
        end else if (haltRise) begin
            sel <= 1'b0;
        end else if (wrCk) begin
            if (bake) begin
                sel <= wrData[BIT_SEL] && !flag;
            end else begin
                sel <= wrData[BIT_SEL];
            end
        end
    end

    // Wanted source: a halt under backup overrides the select bit
    assign target = sel && !haltSeen;

    // Break-before-make source switch
    assign setFlag   = (state == ST_GAP_TO_RC) && (gapCnt == GAP_LAST) && clkIsExt;
    assign toExtDone = (state == ST_GAP_TO_EXT) && (gapCnt == GAP_LAST) && target;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= ST_ON_RC;
            gapCnt     <= '0;
            rcClkGate  <= 1'b1;
            extClkGate <= 1'b0;
            clkIsExt   <= 1'b0;
        end else begin
            case (state)
                ST_ON_RC: begin
                    if (target) begin
                        state     <= ST_GAP_TO_EXT;
                        rcClkGate <= 1'b0;
                        gapCnt    <= '0;
                    end
                end
                ST_GAP_TO_EXT: begin
                    if (!target) begin
                        state  <= ST_GAP_TO_RC;
                        gapCnt <= '0;
                    end else if (gapCnt == GAP_LAST) begin
                        state      <= ST_ON_EXT;
                        extClkGate <= 1'b1;
                        clkIsExt   <= 1'b1;
                    end else begin
                        gapCnt <= gapCnt + 1'b1;
                    end
                end
                ST_ON_EXT: begin
                    if (!target) begin
                        state      <= ST_GAP_TO_RC;
                        extClkGate <= 1'b0;
                        gapCnt     <= '0;
                    end
                end
                ST_GAP_TO_RC: begin
                    if (gapCnt == GAP_LAST) begin
                        state     <= ST_ON_RC;
                        rcClkGate <= 1'b1;
                        clkIsExt  <= 1'b0;
                    end else begin
                        gapCnt <= gapCnt + 1'b1;
                    end
                end
                default: begin
                    state      <= ST_ON_RC;
                    rcClkGate  <= 1'b1;
                    extClkGate <= 1'b0;
                    clkIsExt   <= 1'b0;
                end
            endcase
        end
    end

    // Switch flag: read as 1 arms the clear, the next write of 0 clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (wrCk) begin
            armed <= 1'b0;
        end else if (rdCk) begin
            armed <= flag;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag <= RST_FLAG;
        end else if (setFlag) begin
            flag <= 1'b1;
        end else if (wrCk && armed && !wrData[BIT_FLAG]) begin
            flag <= 1'b0;
        end
    end

    // Oscillator trim: default caught at the first edge after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trimLoaded <= 1'b0;
            trimValue  <= RST_TRIM;
        end else if (!trimLoaded) begin
            trimLoaded <= 1'b1;
            trimValue  <= trimDefault;
        end else if (wrEn && (addr == ADDR_TRIM)) begin
            trimValue <= wrData;
        end
    end

    // Reference input: sampled on the local clock, three stages
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refS1    <= 1'b0;
            refS2    <= 1'b0;
            refS3    <= 1'b0;
            refLevel <= 1'b0;
        end else begin
            refS1 <= refIn;
            refS2 <= refS1;
            refS3 <= refS2;
            if (refS2 == refS3) begin
                refLevel <= refS3;
            end
        end
    end

    assign refRise = (refS2 == refS3) && refS3 && !refLevel;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refCnt    <= '0;
            refPeriod <= '0;
        end else if (refRise) begin
            refPeriod <= refCnt;
            refCnt    <= REF_W'(1);
        end else if (!(&refCnt)) begin
            refCnt <= refCnt + 1'b1;
        end
    end

    assign refView = 16'(refPeriod);

    // Events: sticky, read clears, set wins
    assign evtSet[EVT_TO_RC]  = setFlag;
    assign evtSet[EVT_HALT]   = haltRise;
    assign evtSet[EVT_TO_EXT] = toExtDone;
    assign evtSet[EVT_REF]    = refRise;

    for (genvar i = 0; i < EVT_W; i++) begin : g_evt
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                evtStatus[i] <= 1'b0;
            end else begin
                evtStatus[i] <= evtSet[i] || (evtStatus[i] && !rdEvt);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evtMask <= RST_EVT_MASK;
        end else if (wrEn && (addr == ADDR_EVT_MASK)) begin
            evtMask <= wrData[EVT_W-1:0];
        end
    end

    // Interrupt output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= (flag && ie) || (|(evtStatus & evtMask));
        end
    end

    // Register read
    always_comb begin
        ctrlView           = 8'h00;
        ctrlView[BIT_BAKE] = bake;
        ctrlView[BIT_SEL]  = sel;
        ctrlView[BIT_IE]   = ie;
        ctrlView[BIT_FLAG] = flag;
        ctrlView[BIT_HALT] = bake ? halted : 1'b1;
        ctrlView[BIT_STA]  = clkIsExt;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (rdEn) begin
            case (addr)
                ADDR_CTRL:       rdData <= ctrlView;
                ADDR_TRIM:       rdData <= trimValue;
                ADDR_EVT_STATUS: rdData <= 8'(evtStatus);
                ADDR_EVT_MASK:   rdData <= 8'(evtMask);
                ADDR_REF_LO:     rdData <= refView[7:0];
                ADDR_REF_HI:     rdData <= refView[15:8];
                default:         rdData <= 8'h00;
            endcase
        end else begin
            rdData <= 8'h00;
        end
    end

    // Checks
    a_detect_idle: assert property (@(posedge clk) disable iff (rst)
        !bake ##1 !bake |-> halted)
        else $error("halt detector active with backup off");

    a_backup_fallback: assert property (@(posedge clk) disable iff (rst)
        (bake && halted && clkIsExt) |-> ##[1:8] !clkIsExt)
        else $error("no fallback to on-chip oscillator after halt");

    a_forced_select: assert property (@(posedge clk) disable iff (rst)
        (!bake && sel && state == ST_ON_RC) |-> ##[1:8] (extClkGate || !sel))
        else $error("forced external select not honoured");

    a_sel_blocked: assert property (@(posedge clk) disable iff (rst)
        (bake && wrCk && flag) |=> !sel)
        else $error("select set while switch flag is 1");

    a_halt_clears_sel: assert property (@(posedge clk) disable iff (rst)
        (bake && halted && !prevHalted) |=> !sel)
        else $error("select not cleared on halt");

    a_irq_quiet: assert property (@(posedge clk) disable iff (rst)
        (!(flag && ie) && ((evtStatus & evtMask) == '0)) |=> !irq)
        else $error("interrupt without enabled cause");

    a_flag_on_fall: assert property (@(posedge clk) disable iff (rst)
        $fell(clkIsExt) |-> flag)
        else $error("switch flag not set on move to on-chip oscillator");

    a_flag_no_blind: assert property (@(posedge clk) disable iff (rst)
        (flag && wrCk && !armed) |=> flag)
        else $error("switch flag cleared without prior read");

    a_halt_read_on: assert property (@(posedge clk) disable iff (rst)
        (rdCk && bake) |=> rdData[BIT_HALT] == $past(halted))
        else $error("halt bit does not follow detector");

    a_halt_read_off: assert property (@(posedge clk) disable iff (rst)
        (rdCk && !bake) |=> rdData[BIT_HALT])
        else $error("halt bit not 1 with backup off");

    a_status_gate: assert property (@(posedge clk) disable iff (rst)
        extClkGate |-> clkIsExt)
        else $error("clock status disagrees with external gate");

    a_rc_idle: assert property (@(posedge clk) disable iff (rst)
        (state == ST_ON_RC) |-> (rcClkGate && !clkIsExt))
        else $error("idle state not on on-chip oscillator");

    a_trim_reload: assert property (@(posedge clk) disable iff (rst)
        !trimLoaded |=> trimValue == $past(trimDefault))
        else $error("trim not reloaded after reset");

    a_gates_exclusive: assert property (@(posedge clk) disable iff (rst)
        !(rcClkGate && extClkGate))
        else $error("both clock sources enabled");

endmodule

// ==== hdl/scs_pkg.sv ====
// Purpose: Shared constants and types for the system clock source switch
// Assumes: 100 MHz register clock, 8-bit register port
// Notes:   Offsets are register indices on the plain register port
package scs_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 10;

    // Register indices
    localparam logic [2:0] ADDR_CTRL       = 3'h0;
    localparam logic [2:0] ADDR_TRIM       = 3'h1;
    localparam logic [2:0] ADDR_EVT_STATUS = 3'h2;
    localparam logic [2:0] ADDR_EVT_MASK   = 3'h3;
    localparam logic [2:0] ADDR_REF_LO     = 3'h4;
    localparam logic [2:0] ADDR_REF_HI     = 3'h5;

    // clock_control_status field positions
    localparam int BIT_BAKE = 5;
    localparam int BIT_SEL  = 4;
    localparam int BIT_IE   = 3;
    localparam int BIT_FLAG = 2;
    localparam int BIT_HALT = 1;
    localparam int BIT_STA  = 0;

    // Event status / mask field positions
    localparam int EVT_TO_RC  = 0;
    localparam int EVT_HALT   = 1;
    localparam int EVT_TO_EXT = 2;
    localparam int EVT_REF    = 3;
    localparam int EVT_W      = 4;

    // Values after reset
    localparam logic             RST_BAKE     = 1'b0;
    localparam logic             RST_SEL      = 1'b0;
    localparam logic             RST_IE       = 1'b0;
    localparam logic             RST_FLAG     = 1'b0;
    localparam logic             RST_HALT     = 1'b1;
    localparam logic [EVT_W-1:0] RST_EVT_MASK = 4'h0;
    localparam logic [7:0]       RST_TRIM     = 8'h00;

    // Timing: halt timeout is a longest time, switch gap a least time
    localparam int HALT_TIME_NS      = 1000;
    localparam int HALT_CYCLES       = HALT_TIME_NS / CLK_PERIOD_NS;
    localparam int SWITCH_GAP_NS     = 40;
    localparam int SWITCH_GAP_CYCLES = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_W             = 4;
    localparam logic [GAP_W-1:0] GAP_LAST = 4'(SWITCH_GAP_CYCLES - 1);

    // Source switch sequence
    typedef enum logic [1:0] {
        ST_ON_RC,
        ST_GAP_TO_EXT,
        ST_ON_EXT,
        ST_GAP_TO_RC
    } scs_state_t;

endpackage

// ==== hdl/scs_halt_detect.sv ====
// Purpose: External oscillator halt detector
// Assumes: extOsc is asynchronous to clk and much slower than clk
// Notes:   Reports halted while disabled or while no edge is seen in TIMEOUT cycles
module scs_halt_detect
    import scs_pkg::*;
#(
    parameter int TIMEOUT = HALT_CYCLES,
    parameter int CW      = 16
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic enable,
    // External oscillator pin
    input  wire logic extOsc,
    // Result
    output logic      halted
);

    logic          sync1;
    logic          sync2;
    logic          sync3;
    logic          level;
    logic          change;
    logic [CW-1:0] cnt;

    // Three-stage synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= extOsc;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Accept a new level once stages two and three agree
    assign change = (sync2 == sync3) && (sync3 != level);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= 1'b0;
        end else if (change) begin
            level <= sync3;
        end
    end

    // Edge watchdog
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt    <= '0;
            halted <= RST_HALT;
        end else if (!enable) begin
            cnt    <= '0;
            halted <= 1'b1;
        end else if (change) begin
            cnt    <= '0;
            halted <= 1'b0;
        end else if (cnt == CW'(TIMEOUT - 1)) begin
            halted <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

endmodule

// ==== verif/scs_ext_osc_model.sv ====
// Purpose: External oscillator seen at the clock source switch pin
// Assumes: Free-running square wave while run is high
// Notes:   A halted oscillator freezes its pin at the last level
module scs_ext_osc_model #(
    parameter int HALF_NS = 30
) (
    // Control
    input  wire logic run,
    // Oscillator pin
    output logic      osc
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        osc = 1'b0;
        forever begin
            #HALF_NS;
            if (run) begin
                osc = ~osc;
            end
        end
    end
endmodule

// ==== verif/system_clock_source_switch_tb_top.sv ====
// Purpose: Self-checking bench for the system clock source switch
// Assumes: Shortened halt timeout of 20 cycles, oscillator edges every 3 cycles
// Notes:   Register tasks follow the one-cycle strobe port
module system_clock_source_switch_tb_top import scs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] TRIM_DEF = 8'hA5;

    logic       clk;
    logic       rst;
    logic [2:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
    logic       rdEn;
    logic [7:0] rdData;
    logic       extOsc;
    logic       refIn;
    logic [7:0] trimValue;
    logic       rcClkGate;
    logic       extClkGate;
    logic       clkIsExt;
    logic       irq;
    logic       oscRun;
    logic [7:0] lo;
    logic [7:0] hi;
    int         miscompares;
    int         compares;

    scs_clock_switch #(.HALT_TIMEOUT(20), .REF_W(16)) dut (
        .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
        .rdEn(rdEn), .rdData(rdData), .extOsc(extOsc), .refIn(refIn),
        .trimDefault(TRIM_DEF), .trimValue(trimValue), .rcClkGate(rcClkGate),
        .extClkGate(extClkGate), .clkIsExt(clkIsExt), .irq(irq)
    );

    scs_ext_osc_model #(.HALF_NS(30)) osc (.run(oscRun), .osc(extOsc));

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    task automatic fail_msg(input logic [15:0] got, input logic [15:0] exp);
        miscompares++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_msg({8'h00, got}, {8'h00, exp});
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fail_msg({15'h0000, got}, {15'h0000, exp});
        end
    endtask

    task automatic chk_near(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp && got !== exp + 16'h0001 && got !== exp - 16'h0001) begin
            fail_msg(got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        wrData <= d;
        wrEn   <= 1'b1;
        @(posedge clk);
        wrEn   <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        d = rdData;
    endtask

    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk8(d, exp);
    endtask

    task automatic wait_ext(input logic v);
        int n;
        n = 0;
        while (clkIsExt !== v && n < 80) begin
            @(posedge clk);
            n++;
        end
        #1;
        chk1(clkIsExt, v);
    endtask

    task automatic do_reset;
        rst <= 1'b1;
        idle(3);
        rst <= 1'b0;
        idle(2);
        #1;
    endtask

    task automatic give_verdict;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Gate overlap monitor
    always @(posedge clk) begin
        if (rcClkGate === 1'b1 && extClkGate === 1'b1) begin
            fail_msg(16'h0003, 16'h0000);
        end
    end

    initial begin
        idle(20000);
        miscompares++;
        give_verdict();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        addr = 3'h0;
        wrData = 8'h00;
        wrEn = 1'b0;
        rdEn = 1'b0;
        refIn = 1'b0;
        oscRun = 1'b1;
        miscompares = 0;
        compares = 0;
        do_reset();
        chk8(trimValue, TRIM_DEF);
        chk1(rcClkGate, 1'b1);
        chk1(clkIsExt, 1'b0);
        rdchk(ADDR_CTRL, 8'h02);
        rdchk(3'h7, 8'h00);
        wr(3'h6, 8'hFF);
        rdchk(3'h6, 8'h00);
        wr(ADDR_EVT_MASK, 8'h01);
        // Backup off: forced selection
        wr(ADDR_CTRL, 8'h10);
        wait_ext(1'b1);
        rdchk(ADDR_CTRL, 8'h13);
        wr(ADDR_CTRL, 8'h00);
        wait_ext(1'b0);
        idle(2);
        chk1(irq, 1'b1);
        rdchk(ADDR_EVT_STATUS, 8'h05);
        idle(2);
        chk1(irq, 1'b0);
        // Flag clear needs a prior read
        wr(ADDR_CTRL, 8'h08);
        rdchk(ADDR_CTRL, 8'h0E);
        chk1(irq, 1'b1);
        wr(ADDR_CTRL, 8'h08);
        rdchk(ADDR_CTRL, 8'h0A);
        chk1(irq, 1'b0);
        // Backup on
        wr(ADDR_CTRL, 8'h20);
        idle(30);
        rdchk(ADDR_CTRL, 8'h20);
        wr(ADDR_CTRL, 8'h30);
        wait_ext(1'b1);
        rdchk(ADDR_CTRL, 8'h31);
        oscRun <= 1'b0;
        wait_ext(1'b0);
        rdchk(ADDR_CTRL, 8'h26);
        rdchk(ADDR_EVT_STATUS, 8'h07);
        oscRun <= 1'b1;
        idle(30);
        wr(ADDR_CTRL, 8'h24);
        wr(ADDR_CTRL, 8'h30);
        idle(10);
        chk1(clkIsExt, 1'b0);
        rdchk(ADDR_CTRL, 8'h24);
        wr(ADDR_CTRL, 8'h20);
        wr(ADDR_CTRL, 8'h30);
        wait_ext(1'b1);
        wr(ADDR_CTRL, 8'h20);
        wait_ext(1'b0);
        rdchk(ADDR_CTRL, 8'h24);
        // Reference period, 50 cycles between rises
        repeat (4) begin
            @(posedge clk);
            refIn <= 1'b1;
            idle(5);
            refIn <= 1'b0;
            idle(44);
        end
        rd(ADDR_REF_LO, lo);
        rd(ADDR_REF_HI, hi);
        chk_near({hi, lo}, 16'h0032);
        // Trim is reloaded by reset
        wr(ADDR_TRIM, 8'h5A);
        rdchk(ADDR_TRIM, 8'h5A);
        chk8(trimValue, 8'h5A);
        do_reset();
        chk8(trimValue, TRIM_DEF);
        rdchk(ADDR_CTRL, 8'h02);
        chk1(clkIsExt, 1'b0);
        give_verdict();
    end
endmodule
